// ---- design/sar_report.v ----
// Attribute-values report builder: command decode, sector buffer fill, readout, APB registers.
//
// Summary of operation
// - Accept only SMART command B0h with subcommand selector D0h and signature C24Fh in the track number.
// - On acceptance raise busy and fill the sector buffer before offering data.
// - After filling: raise data request, then drop busy, then raise interrupt.
// - Report is exactly one 512-byte block, read out completely by the host.
// - Bytes 0-1 carry structure revision 0010h.
// - Bytes 2-361 hold thirty 12-byte attribute entries, identifier first.
// - An entry with identifier zero is an unused slot.
// - Flag bit 0 marks pre-failure when set, advisory when clear.
// - Flag bit 1 online update; bits 2-5 class; bits 6-15 reserved.
// - Entry byte 3 is the normalised value, starting at 64h.
// - Entry byte 4 is the worst value, limited to 01h-FEh.
// - Entry bytes 5-10 raw data; byte 11 reserved as 00h.
// - Identifier 199 starts its normalised value at C8h.
// - Byte 362 reports off-line collection state.
// - Byte 362 also reports suspended, host-aborted and device-aborted states.
// - Byte 363 low nibble gives self-test remaining tenths, 0 to 9.
// - Byte 363 high nibble is self-test state; 15 means in progress.
// - Self-test state codes 0 to 7 as defined for pass and failures.
// - Bytes 364-365 give total off-line collection time in seconds.
// - Byte 370 bit 0 set for error logging support; bit 7 reserved.
// - Bytes 372 and 373 give short and extended polling times in minutes.
// - Byte 511 is checksum over bytes 0-510; bytes 374-510 reserved.
`include "sar_consts.vh"

module sar_report #(
  parameter ENTRIES = 30
) (
  // Clock and reset.
  input wire mclk,
  input wire rstn,
  // Task-file command from the host interface logic.
  input wire cmdStrobe,
  input wire [7:0] cmdCode,
  input wire [7:0] subcommandSelector,
  input wire [15:0] trackNumber,
  // Data register readout.
  input wire dataRdStrobe,
  output reg [7:0] dataOut_r,
  output reg dataValid_r,
  // Task-file status.
  input wire intAck,
  output reg busy_r,
  output reg dataReq_r,
  output reg intrq_r,
  output reg abortErr_r,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);

  // ========================================================================
  // State encoding
  // ========================================================================
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_FILL = 5'b00010;
  localparam [4:0] ST_DRQ = 5'b00100;
  localparam [4:0] ST_REL = 5'b01000;
  localparam [4:0] ST_XFER = 5'b10000;

  reg [4:0] state_r;
  reg [8:0] idx_r;
  reg phase_r;
  reg [3:0] entOff_r;
  reg [4:0] entIdx_r;
  reg [7:0] entId_r;
  reg [7:0] sum_r;
  reg [9:0] xferCnt_r;
  reg [8:0] rdPtr_r;
  reg rdPend_r;
  reg [ENTRIES-1:0] valueSet_r;
  reg errLog_r;
  reg [7:0] offline_r;
  reg [7:0] selfTest_r;
  reg [15:0] totalTime_r;
  reg [31:0] caps_r;
  reg [15:0] poll_r;
  reg [7:0] fillByte;
  wire [7:0] attrQ;
  wire [7:0] bufQ;
  wire [8:0] attrRdAddr;
  wire fillWr;
  wire [8:0] bufRdAddr;

  // ========================================================================
  // APB decode
  // ========================================================================
  wire apbSetup = psel & ~penable;
  wire apbDone = psel & penable & pready;
  wire apbWr = apbDone & pwrite;
  wire [11:0] attrOff = paddr - `SAR_ATTR_BASE;
  wire attrHit = (paddr >= `SAR_ATTR_BASE) && !attrOff[11] && (attrOff[10:2] < `SAR_ATTR_BYTES);
  wire [8:0] attrByte = attrOff[10:2];
  wire [8:0] wrSlotW = attrByte / 9'd12;
  wire [8:0] wrOffW = attrByte - wrSlotW * 9'd12;
  wire regHit = paddr == `SAR_REG_CTRL || paddr == `SAR_REG_OFFLINE ||
    paddr == `SAR_REG_SELFTEST || paddr == `SAR_REG_TOTAL_TIME ||
    paddr == `SAR_REG_CAPS || paddr == `SAR_REG_POLL || paddr == `SAR_REG_STATUS;
  // Writes into the attribute store are blocked while a report is being built.
  wire attrWr = apbWr & attrHit & (state_r != ST_FILL);

  // One wait-free access: answer is prepared in the setup cycle.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (apbSetup) begin
      pready <= 1'b1;
      pslverr <= ~(regHit | attrHit);
      case (paddr)
        `SAR_REG_CTRL: prdata <= {31'h0000_0000, errLog_r};
        `SAR_REG_OFFLINE: prdata <= {24'h00_0000, offline_r};
        `SAR_REG_SELFTEST: prdata <= {24'h00_0000, selfTest_r};
        `SAR_REG_TOTAL_TIME: prdata <= {16'h0000, totalTime_r};
        `SAR_REG_CAPS: prdata <= caps_r;
        `SAR_REG_POLL: prdata <= {16'h0000, poll_r};
        `SAR_REG_STATUS: prdata <= {12'h000, xferCnt_r, 6'h00,
          abortErr_r, intrq_r, dataReq_r, busy_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software-held report fields.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      errLog_r <= `SAR_CTRL_RST;
      offline_r <= `SAR_OFFLINE_RST;
      selfTest_r <= `SAR_SELFTEST_RST;
      totalTime_r <= `SAR_TOTAL_TIME_RST;
      caps_r <= `SAR_CAPS_RST;
      poll_r <= `SAR_POLL_RST;
    end else if (apbWr) begin
      case (paddr)
        `SAR_REG_CTRL: errLog_r <= pwdata[0];
        `SAR_REG_OFFLINE: offline_r <= pwdata[7:0];
        `SAR_REG_SELFTEST: selfTest_r <= pwdata[7:0];
        `SAR_REG_TOTAL_TIME: totalTime_r <= pwdata[15:0];
        `SAR_REG_CAPS: caps_r <= pwdata;
        `SAR_REG_POLL: poll_r <= pwdata[15:0];
        default: errLog_r <= errLog_r;
      endcase
    end
  end

  // A slot whose normalised value was never written reports its start value.
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : gSlot
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          valueSet_r[g] <= 1'b0;
        end else if (attrWr && wrSlotW == g && wrOffW == 9'd3) begin
          valueSet_r[g] <= 1'b1;
        end
      end
    end
  endgenerate

  // ========================================================================
  // Memories
  // ========================================================================
  assign attrRdAddr = idx_r - `SAR_ENTRY_FIRST;

  // Attribute store, one byte per APB word.
  sar_buf_mem #(.WIDTH(8), .DEPTH(360), .AW(9)) uAttr (
    .mclk(mclk),
    .wrEn(attrWr),
    .wrAddr(attrByte),
    .wrData(pwdata[7:0]),
    .rdAddr(attrRdAddr),
    .rdData(attrQ)
  );

  assign fillWr = (state_r == ST_FILL) & phase_r;
  assign bufRdAddr = rdPtr_r;

  // Sector buffer holding the finished report.
  sar_buf_mem #(.WIDTH(8), .DEPTH(512), .AW(9)) uBuf (
    .mclk(mclk),
    .wrEn(fillWr),
    .wrAddr(idx_r),
    .wrData(fillByte),
    .rdAddr(bufRdAddr),
    .rdData(bufQ)
  );

  // ========================================================================
  // Report byte generation
  // ========================================================================
  wire inEntry = idx_r >= `SAR_ENTRY_FIRST && idx_r <= `SAR_ENTRY_LAST;
  wire [7:0] curId = (entOff_r == 4'd0) ? attrQ : entId_r;
  wire [7:0] normInit = (curId == `SAR_ID_CRC) ? `SAR_NORM_INIT_CRC : `SAR_NORM_INIT;
  wire slotSet = valueSet_r[entIdx_r];

  // Entry bytes are cleaned so reserved fields never leak stale store contents.
  always @* begin
    fillByte = 8'h00;
    if (idx_r == 9'd0) begin
      fillByte = `SAR_REV_LO;
    end else if (idx_r == 9'd1) begin
      fillByte = `SAR_REV_HI;
    end else if (inEntry) begin
      if (curId == 8'h00) begin
        fillByte = 8'h00;
      end else begin
        case (entOff_r)
          4'd0: fillByte = attrQ;
          4'd1: fillByte = attrQ & `SAR_FLAG_LO_MASK;
          4'd2: fillByte = 8'h00;
          4'd3: fillByte = slotSet ? attrQ : normInit;
          4'd4: begin
            if (!slotSet) begin
              fillByte = normInit;
            end else if (attrQ < `SAR_WORST_MIN) begin
              fillByte = `SAR_WORST_MIN;
            end else if (attrQ > `SAR_WORST_MAX) begin
              fillByte = `SAR_WORST_MAX;
            end else begin
              fillByte = attrQ;
            end
          end
          4'd11: fillByte = 8'h00;
          default: fillByte = attrQ;
        endcase
      end
    end else begin
      case (idx_r)
        `SAR_BYTE_OFFLINE: fillByte = offline_r;
        `SAR_BYTE_SELFTEST: fillByte = {selfTest_r[7:4],
          (selfTest_r[3:0] > `SAR_REMAIN_MAX) ? `SAR_REMAIN_MAX : selfTest_r[3:0]};
        `SAR_BYTE_TIME_LO: fillByte = totalTime_r[7:0];
        `SAR_BYTE_TIME_HI: fillByte = totalTime_r[15:8];
        `SAR_BYTE_OFF_CAP: fillByte = caps_r[7:0];
        `SAR_BYTE_SMART_CAP_LO: fillByte = caps_r[15:8];
        `SAR_BYTE_SMART_CAP_HI: fillByte = caps_r[23:16];
        `SAR_BYTE_ERRLOG: fillByte = {7'h00, errLog_r};
        `SAR_BYTE_CHECKPOINT: fillByte = caps_r[31:24];
        `SAR_BYTE_POLL_SHORT: fillByte = poll_r[7:0];
        `SAR_BYTE_POLL_EXT: fillByte = poll_r[15:8];
        `SAR_LAST_BYTE: fillByte = 8'h00 - sum_r;
        default: fillByte = 8'h00;
      endcase
    end
  end

  // ========================================================================
  // Command sequencer
  // ========================================================================
  wire cmdOk = cmdCode == `SAR_CMD_SMART && subcommandSelector == `SAR_SUB_READ_VALUES &&
    trackNumber == `SAR_SIGNATURE;
  wire readTaken = (state_r == ST_XFER) & dataRdStrobe & ~rdPend_r;
  wire lastRead = readTaken && xferCnt_r == 10'd1;

  // Each report byte takes two cycles: one to fetch the store, one to write.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      idx_r <= 9'd0;
      phase_r <= 1'b0;
      entOff_r <= 4'd0;
      entIdx_r <= 5'd0;
      entId_r <= 8'h00;
      sum_r <= 8'h00;
      busy_r <= 1'b0;
      dataReq_r <= 1'b0;
      abortErr_r <= 1'b0;
      xferCnt_r <= 10'd0;
      rdPtr_r <= 9'd0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cmdStrobe) begin
            abortErr_r <= ~cmdOk;
            if (cmdOk) begin
              busy_r <= 1'b1;
              state_r <= ST_FILL;
              idx_r <= 9'd0;
              phase_r <= 1'b0;
              entOff_r <= 4'd0;
              entIdx_r <= 5'd0;
              sum_r <= 8'h00;
            end
          end
        end
        ST_FILL: begin
          phase_r <= ~phase_r;
          if (phase_r) begin
            sum_r <= sum_r + fillByte;
            if (inEntry) begin
              if (entOff_r == 4'd0) begin
                entId_r <= attrQ;
              end
              if (entOff_r == `SAR_ENTRY_OFF_LAST) begin
                entOff_r <= 4'd0;
                entIdx_r <= entIdx_r + 5'd1;
              end else begin
                entOff_r <= entOff_r + 4'd1;
              end
            end
            if (idx_r == `SAR_LAST_BYTE) begin
              state_r <= ST_DRQ;
            end else begin
              idx_r <= idx_r + 9'd1;
            end
          end
        end
        ST_DRQ: begin
          dataReq_r <= 1'b1;
          xferCnt_r <= `SAR_REPORT_BYTES;
          rdPtr_r <= 9'd0;
          state_r <= ST_REL;
        end
        ST_REL: begin
          busy_r <= 1'b0;
          state_r <= ST_XFER;
        end
        ST_XFER: begin
          if (readTaken) begin
            rdPtr_r <= rdPtr_r + 9'd1;
            xferCnt_r <= xferCnt_r - 10'd1;
          end
          if (lastRead) begin
            dataReq_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Interrupt follows busy release; a new event wins over an acknowledge.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      intrq_r <= 1'b0;
    end else if (state_r == ST_XFER && !dataValid_r && busy_r == 1'b0 &&
        xferCnt_r == `SAR_REPORT_BYTES && !rdPend_r && !intrq_r && !dataRdStrobe) begin
      intrq_r <= 1'b1;
    end else if (state_r == ST_IDLE && cmdStrobe && !cmdOk) begin
      intrq_r <= 1'b1;
    end else if (intAck || cmdStrobe) begin
      intrq_r <= 1'b0;
    end
  end

  // ========================================================================
  // Data register readout
  // ========================================================================
  // The buffer read is registered, so each byte appears two edges after its strobe.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdPend_r <= 1'b0;
      dataValid_r <= 1'b0;
      dataOut_r <= 8'h00;
    end else begin
      rdPend_r <= readTaken;
      dataValid_r <= rdPend_r;
      if (rdPend_r) begin
        dataOut_r <= bufQ;
      end
    end
  end

endmodule // sar_report

// ---- design/sar_consts.vh ----
// Constants for the attribute-values report block: codes, offsets, field positions, reset values.
`ifndef SAR_CONSTS_VH
`define SAR_CONSTS_VH

// ==========================================================================
// Command decode
// ==========================================================================
`define SAR_CMD_SMART 8'hB0
`define SAR_SUB_READ_VALUES 8'hD0
`define SAR_SIGNATURE 16'hC24F

// ==========================================================================
// Report layout (byte positions)
// ==========================================================================
`define SAR_REPORT_BYTES 10'd512
`define SAR_LAST_BYTE 9'd511
`define SAR_REV_LO 8'h10
`define SAR_REV_HI 8'h00
`define SAR_ENTRY_FIRST 9'd2
`define SAR_ENTRY_LAST 9'd361
`define SAR_ENTRY_LEN 4'd12
`define SAR_ENTRY_OFF_LAST 4'd11
`define SAR_BYTE_OFFLINE 9'd362
`define SAR_BYTE_SELFTEST 9'd363
`define SAR_BYTE_TIME_LO 9'd364
`define SAR_BYTE_TIME_HI 9'd365
`define SAR_BYTE_OFF_CAP 9'd367
`define SAR_BYTE_SMART_CAP_LO 9'd368
`define SAR_BYTE_SMART_CAP_HI 9'd369
`define SAR_BYTE_ERRLOG 9'd370
`define SAR_BYTE_CHECKPOINT 9'd371
`define SAR_BYTE_POLL_SHORT 9'd372
`define SAR_BYTE_POLL_EXT 9'd373

// ==========================================================================
// Attribute entry fields
// ==========================================================================
`define SAR_FLAG_LO_MASK 8'h3F
`define SAR_NORM_INIT 8'h64
`define SAR_NORM_INIT_CRC 8'hC8
`define SAR_ID_CRC 8'hC7
`define SAR_WORST_MIN 8'h01
`define SAR_WORST_MAX 8'hFE
`define SAR_REMAIN_MAX 4'h9

// ==========================================================================
// APB register map (byte addresses)
// ==========================================================================
`define SAR_REG_CTRL 12'h000
`define SAR_REG_OFFLINE 12'h004
`define SAR_REG_SELFTEST 12'h008
`define SAR_REG_TOTAL_TIME 12'h00C
`define SAR_REG_CAPS 12'h010
`define SAR_REG_POLL 12'h014
`define SAR_REG_STATUS 12'h018
`define SAR_ATTR_BASE 12'h400
`define SAR_ATTR_BYTES 9'd360

// ==========================================================================
// Register reset values
// ==========================================================================
`define SAR_CTRL_RST 1'b1
`define SAR_OFFLINE_RST 8'h00
`define SAR_SELFTEST_RST 8'h00
`define SAR_TOTAL_TIME_RST 16'h0000
`define SAR_CAPS_RST 32'h0000_0000
`define SAR_POLL_RST 16'h0000

`endif

// ---- design/sar_buf_mem.v ----
// Simple dual-port byte memory with a registered read port.
module sar_buf_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 512,
  parameter AW = 9
) (
  // Clock.
  input wire mclk,
  // Write port.
  input wire wrEn,
  input wire [AW-1:0] wrAddr,
  input wire [WIDTH-1:0] wrData,
  // Read port.
  input wire [AW-1:0] rdAddr,
  output reg [WIDTH-1:0] rdData
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // Storage is not reset; a location read before it is ever written returns unknown data.
  always @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // sar_buf_mem

// ---- test/sar_report_properties.sv ----
// Concurrent checks on the ports of the attribute-values report block.
`include "sar_consts.vh"

module sar_report_properties #(
  parameter ENTRIES = 30
) (
  // Clock and reset.
  input wire mclk,
  input wire rstn,
  // Command and readout.
  input wire cmdStrobe,
  input wire [7:0] cmdCode,
  input wire [7:0] subcommandSelector,
  input wire [15:0] trackNumber,
  input wire dataRdStrobe,
  input wire [7:0] dataOut_r,
  input wire dataValid_r,
  input wire intAck,
  input wire busy_r,
  input wire dataReq_r,
  input wire intrq_r,
  input wire abortErr_r,
  // APB.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  wire idle = !busy_r && !dataReq_r;
  wire cmdOk = cmdCode == `SAR_CMD_SMART && subcommandSelector == `SAR_SUB_READ_VALUES &&
    trackNumber == `SAR_SIGNATURE;
  logic [10:0] fillCnt_r;

  // Counts fill cycles; it saturates so a stuck fill cannot wrap into a legal count.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fillCnt_r <= 11'h000;
    end else if (!busy_r) begin
      fillCnt_r <= 11'h000;
    end else if (!dataReq_r && fillCnt_r != 11'h7FF) begin
      fillCnt_r <= fillCnt_r + 11'h001;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Command, fill and readout ordering
  // ==========================================================================
  property p_accept; cmdStrobe && idle && cmdOk |=> busy_r && !abortErr_r; endproperty
  a_accept: assert property (p_accept) else $error("command not accepted");
  property p_reject; cmdStrobe && idle && !cmdOk |=> abortErr_r && intrq_r && !busy_r; endproperty
  a_reject: assert property (p_reject) else $error("bad command not rejected");
  property p_ignore; cmdStrobe && !idle |=> $stable(abortErr_r); endproperty
  a_ignore: assert property (p_ignore) else $error("command taken while busy");
  property p_fill; $rose(dataReq_r) |-> fillCnt_r inside {[1023:1025]}; endproperty
  a_fill: assert property (p_fill) else $error("fill length wrong");
  property p_quiet; busy_r && !dataReq_r |-> !intrq_r && !dataValid_r; endproperty
  a_quiet: assert property (p_quiet) else $error("activity during fill");
  property p_order; $rose(dataReq_r) |-> busy_r ##1 !busy_r; endproperty
  a_order: assert property (p_order) else $error("busy not released after data request");
  property p_intr; $fell(busy_r) && dataReq_r |-> ##[0:2] intrq_r; endproperty
  a_intr: assert property (p_intr) else $error("no interrupt after busy release");
  property p_lat; dataRdStrobe && dataReq_r && !$past(dataRdStrobe) |-> ##2 dataValid_r; endproperty
  a_lat: assert property (p_lat) else $error("read byte not delivered");
  property p_pulse; dataValid_r |=> !dataValid_r; endproperty
  a_pulse: assert property (p_pulse) else $error("data valid longer than one cycle");
  property p_src; dataValid_r |-> $past(dataReq_r, 2); endproperty
  a_src: assert property (p_src) else $error("data without data request");
endmodule // sar_report_properties

bind sar_report sar_report_properties #(.ENTRIES(ENTRIES)) sar_report_properties_inst (
  .mclk(mclk), .rstn(rstn), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
  .subcommandSelector(subcommandSelector), .trackNumber(trackNumber),
  .dataRdStrobe(dataRdStrobe), .dataOut_r(dataOut_r), .dataValid_r(dataValid_r),
  .intAck(intAck), .busy_r(busy_r), .dataReq_r(dataReq_r), .intrq_r(intrq_r),
  .abortErr_r(abortErr_r), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// ---- test/sar_host_model.sv ----
// Host controller model that issues the report command and reads the data block.
module sar_host_model (
  // Clock.
  input wire mclk,
  // Task file toward the device.
  output logic cmdStrobe,
  output logic [7:0] cmdCode,
  output logic [7:0] subcommandSelector,
  output logic [15:0] trackNumber,
  output logic dataRdStrobe,
  output logic intAck,
  // Device status and data.
  input wire [7:0] dataOut_r,
  input wire dataValid_r,
  input wire intrq_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx [0:511];

  // Idle levels at time zero.
  initial begin
    cmdStrobe = 1'b0;
    cmdCode = 8'h00;
    subcommandSelector = 8'h00;
    trackNumber = 16'h0000;
    dataRdStrobe = 1'b0;
    intAck = 1'b0;
  end

  // Fields are valid only with the strobe; afterwards they flip so late sampling shows.
  task automatic issue(input logic [7:0] c, input logic [7:0] s, input logic [15:0] t);
    cmdStrobe <= 1'b1;
    cmdCode <= c;
    subcommandSelector <= s;
    trackNumber <= t;
    @(posedge mclk);
    cmdStrobe <= 1'b0;
    cmdCode <= ~c;
    subcommandSelector <= ~s;
    trackNumber <= ~t;
  endtask

  // Status read that acknowledges the interrupt.
  task automatic ack();
    intAck <= 1'b1;
    @(posedge mclk);
    intAck <= 1'b0;
  endtask

  // The host reads only after the interrupt tells it data is ready.
  task automatic waitIntr(output bit ok);
    int w;
    w = 0;
    while (intrq_r !== 1'b1 && w < 3000) begin
      @(posedge mclk);
      w++;
    end
    ok = w < 3000;
  endtask

  // Reads the whole block, one strobe per byte, never closer than the device allows.
  task automatic readBlock(output bit ok);
    int w;
    ok = 1'b1;
    ack();
    for (int i = 0; i < 512; i++) begin
      dataRdStrobe <= 1'b1;
      @(posedge mclk);
      dataRdStrobe <= 1'b0;
      w = 0;
      do begin
        @(posedge mclk);
        w++;
      end while (dataValid_r !== 1'b1 && w < 8);
      rx[i] = dataOut_r;
      if (w >= 8) ok = 1'b0;
    end
  endtask
endmodule // sar_host_model

// ---- test/sar_report_tb.sv ----
// Self-checking bench for the attribute-values report block.
`include "sar_consts.vh"

module sar_report_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, psel, penable, pwrite, err, ctrlV;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, capsV;
  logic [7:0] offV, stV;
  logic [15:0] timeV, pollV;
  logic [7:0] attr [0:359];
  wire cmdStrobe, dataRdStrobe, intAck, dataValid_r, busy_r, dataReq_r, intrq_r, abortErr_r;
  wire pready, pslverr;
  wire [7:0] cmdCode, subcommandSelector, dataOut_r;
  wire [15:0] trackNumber;
  wire [31:0] prdata;
  int errTotal, testsRun;
  bit ok;

  sar_report sar_report_inst (
    .mclk(mclk), .rstn(rstn), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
    .subcommandSelector(subcommandSelector), .trackNumber(trackNumber),
    .dataRdStrobe(dataRdStrobe), .dataOut_r(dataOut_r), .dataValid_r(dataValid_r),
    .intAck(intAck), .busy_r(busy_r), .dataReq_r(dataReq_r), .intrq_r(intrq_r),
    .abortErr_r(abortErr_r), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  sar_host_model sar_host_model_inst (
    .mclk(mclk), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
    .subcommandSelector(subcommandSelector), .trackNumber(trackNumber),
    .dataRdStrobe(dataRdStrobe), .intAck(intAck), .dataOut_r(dataOut_r),
    .dataValid_r(dataValid_r), .intrq_r(intrq_r)
  );

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic summarize();
    if (errTotal == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    if (n >= 16) begin
      errTotal++;
      summarize();
    end
  endtask

  // Expected report byte; unset normalised slots fall back to their start value.
  function automatic logic [7:0] expB(int i);
    int k, n, j;
    logic [7:0] v;
    if (i < 2) return (i == 0) ? `SAR_REV_LO : `SAR_REV_HI;
    if (i <= 361) begin
      k = i - 2;
      n = k / 12;
      j = k % 12;
      v = attr[k];
      if (attr[n * 12] == 8'h00) return 8'h00;
      if (j == 1) return v & `SAR_FLAG_LO_MASK;
      if (j == 2 || j == 11) return 8'h00;
      if (j == 0 || j > 4) return v;
      if (n < 2) return (n == 1) ? `SAR_NORM_INIT_CRC : `SAR_NORM_INIT;
      if (j == 3) return v;
      return (v == 8'h00) ? 8'h01 : (v == 8'hFF) ? 8'hFE : v;
    end
    case (i)
      362: return offV;
      363: return {stV[7:4], (stV[3:0] > 4'h9) ? 4'h9 : stV[3:0]};
      364: return timeV[7:0];
      365: return timeV[15:8];
      367: return capsV[7:0];
      368: return capsV[15:8];
      369: return capsV[23:16];
      370: return {7'h00, ctrlV};
      371: return capsV[31:24];
      372: return pollV[7:0];
      373: return pollV[15:8];
      default: return 8'h00;
    endcase
  endfunction

  // Loads the status registers, runs one report and compares every byte.
  task automatic runReport();
    logic [7:0] sum;
    apb(1'b1, `SAR_REG_CTRL, {31'h0, ctrlV});
    apb(1'b1, `SAR_REG_OFFLINE, {24'h0, offV});
    apb(1'b1, `SAR_REG_SELFTEST, {24'h0, stV});
    apb(1'b1, `SAR_REG_TOTAL_TIME, {16'h0, timeV});
    apb(1'b1, `SAR_REG_CAPS, capsV);
    apb(1'b1, `SAR_REG_POLL, {16'h0, pollV});
    sar_host_model_inst.issue(`SAR_CMD_SMART, `SAR_SUB_READ_VALUES, `SAR_SIGNATURE);
    @(posedge mclk);
    check("busy", busy_r, 32'h1);
    sar_host_model_inst.issue(8'h00, 8'h00, 16'h0000);
    @(posedge mclk);
    check("abortDuringFill", abortErr_r, 32'h0);
    sar_host_model_inst.waitIntr(ok);
    check("intrWait", ok, 32'h1);
    apb(1'b0, `SAR_REG_STATUS, 32'h0);
    check("statusReady", rd, 32'h0008_0006);
    sar_host_model_inst.readBlock(ok);
    check("readWait", ok, 32'h1);
    sum = 8'h00;
    for (int i = 0; i < 511; i++) begin
      check($sformatf("byte%0d", i), sar_host_model_inst.rx[i], expB(i));
      sum += expB(i);
    end
    check("checksum", sar_host_model_inst.rx[511], 8'(8'h00 - sum));
    apb(1'b0, `SAR_REG_STATUS, 32'h0);
    check("statusDone", rd, 32'h0);
  endtask

  // ==========================================================================
  // Clock and main sequence
  // ==========================================================================
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    errTotal = 0;
    testsRun = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, 12'(4 * k), 32'h0);
      check("resetReg", rd, (k == 0) ? 32'h1 : 32'h0);
    end
    apb(1'b1, 12'h020, 32'hFFFF_FFFF);
    apb(1'b0, 12'h020, 32'h0);
    check("unmappedErr", err, 32'h1);
    check("unmappedData", rd, 32'h0);
    // Entry 2 is an unused slot; entries 3 and 4 push worst values past both ends.
    for (int k = 0; k < 360; k++) begin
      attr[k] = (k % 12 == 0) ? 8'(k / 12 + 1) : 8'(k * 37 + 3);
    end
    attr[12] = `SAR_ID_CRC;
    attr[24] = 8'h00;
    attr[40] = 8'h00;
    attr[52] = 8'hFF;
    // Normalised and worst bytes of entries 0 and 1 stay unwritten to show start values.
    for (int k = 0; k < 360; k++) begin
      if (k > 23 || k % 12 < 3 || k % 12 > 4) apb(1'b1, `SAR_ATTR_BASE + 12'(4 * k), {24'h0, attr[k]});
    end
    for (int k = 0; k < 3; k++) begin
      sar_host_model_inst.issue((k == 0) ? 8'hB1 : `SAR_CMD_SMART,
        (k == 1) ? 8'hD1 : `SAR_SUB_READ_VALUES, (k == 2) ? 16'hC24E : `SAR_SIGNATURE);
      @(posedge mclk);
      check("abortErr", abortErr_r, 32'h1);
      check("abortBusy", busy_r, 32'h0);
      sar_host_model_inst.ack();
    end
    ctrlV = 1'b1;
    offV = 8'h85;
    stV = 8'hFC;
    timeV = 16'h1234;
    capsV = 32'h4433_2211;
    pollV = 16'h0A02;
    runReport();
    ctrlV = 1'b0;
    offV = 8'h06;
    stV = 8'h79;
    timeV = 16'hFF01;
    capsV = 32'h8000_0001;
    pollV = 16'hFF00;
    runReport();
    summarize();
  end
endmodule // sar_report_tb
